// *** logic/psram_guard_pkg.sv ***
// Constants, mode codes and state encodings for the refresh window guard.
// Assumes a single 25 MHz system clock; every time below is turned into cycles here.
package psram_guard_pkg;

  // ****************************************************************
  // Clock and bus widths
  // ****************************************************************
  localparam int CLK_NS      = 40;    // 25 MHz system clock
  localparam int ADDR_W      = 22;
  localparam int CNT_W       = 7;
  localparam int PAGE_BITS   = 4;     // Sixteen-word page
  localparam int ROW_BITS    = 7;     // Column bits inside one row

  // ****************************************************************
  // Timing figures and derived cycle counts
  // ****************************************************************
  localparam int CEM_NS      = 4000;  // max_select_low_time, longest: round down
  localparam int CBPH_NS     = 5;     // select_high_min_time, least: round up
  localparam int WC_NS       = 70;    // write_cycle_time, least: round up
  localparam int AA_NS       = 70;    // random_access_time
  localparam int APA_NS      = 20;    // page_access_time
  localparam int ROW_OPEN_NS = 70;    // Row open time while the wait flag stands

  localparam logic [CNT_W-1:0] CNT_MAX  = 7'h7F;
  localparam logic [CNT_W-1:0] CEM_CYC  = CNT_W'(CEM_NS / CLK_NS);
  localparam logic [CNT_W-1:0] CBPH_CYC = CNT_W'((CBPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WC_CYC   = CNT_W'((WC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] AA_CYC   = CNT_W'((AA_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] APA_CYC  = CNT_W'((APA_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] ROW_CYC  = CNT_W'((ROW_OPEN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;

  // ****************************************************************
  // Operating modes and burst states
  // ****************************************************************
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_PAGE  = 2'h1;
  localparam logic [1:0] MODE_BURST = 2'h2;

  typedef enum logic [2:0]
  {
    BURST_IDLE = 3'h1,
    BURST_RUN  = 3'h2,
    BURST_ROW  = 3'h4
  } burst_t;

endpackage

// *** logic/psram_refresh_window_guard.sv ***
// Refresh window guard of a pseudo-static RAM: watches the async memory bus,
// finds slots for hidden refresh, slows page reads and opens rows in bursts.
// Assumes all bus inputs are synchronous to I_CLK_SYS and the mode is static.
`timescale 1ns/10ps

module psram_refresh_window_guard
(
  // Clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  // Configuration and internal refresh timer
  input  wire logic [1:0]  I_MODE,
  input  wire logic        I_REFRESH_REQ,
  // Memory bus
  input  wire logic        I_SELECT_N,
  input  wire logic [21:0] I_ADDR,
  input  wire logic        I_WRITE_N,
  input  wire logic        I_OUTPUT_EN_N,
  input  wire logic        I_ADDRESS_LATCH_N,
  // Status towards the array and the bus
  output logic             O_REFRESH_GO,
  output logic             O_LONG_OP,
  output logic             O_SLOW_READ,
  output logic             O_DATA_READY,
  output logic             O_WAIT,
  output logic             O_WINDOW_FAULT
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Saturating counter step, shared by every duration counter that counts up
  function automatic logic [6:0] sat_inc(input logic [6:0] value);
    sat_inc = (value == psram_guard_pkg::CNT_MAX) ? value : value + 7'h01;
  endfunction

  // Duration counters share one width; one saturating step serves the up-counters, acc_cnt and wait_cnt count down
  logic [6:0]          sel_cnt, high_cnt, addr_cnt, wr_cnt;
  logic [6:0]          acc_cnt, row_age, wait_cnt;
  logic [21:0]         addr_q, burst_addr;
  logic [17:0]         last_page;
  logic                page_valid, pend, slow, ext_need, writing_q;
  psram_guard_pkg::burst_t state, next_state;

  logic                writing, reading, addr_chg, long_sel, long_op;
  logic                write_done, slot, go_now, advance;
  logic [6:0]          next_col;

  // ****************************************************************
  // Bus decode and long-operation detection
  // ****************************************************************
  // A long operation in async mode needs both select and address held long
  assign writing    = !I_SELECT_N && !I_WRITE_N;
  assign reading    = !I_SELECT_N && I_WRITE_N && !I_OUTPUT_EN_N;
  assign addr_chg   = I_ADDR != addr_q;
  assign long_sel   = sel_cnt >= psram_guard_pkg::CEM_CYC;
  assign long_op    = (I_MODE == psram_guard_pkg::MODE_ASYNC)
                    ? (writing && long_sel && addr_cnt >= psram_guard_pkg::CEM_CYC)
                    : ((writing || reading) && long_sel);
  assign write_done = writing_q && !writing;

  // Duration counters for select low, select high and address hold
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      sel_cnt  <= psram_guard_pkg::CNT_ZERO;
      high_cnt <= psram_guard_pkg::CNT_ZERO;
      addr_cnt <= psram_guard_pkg::CNT_ZERO;
      addr_q   <= 22'h00_0000;
    end
    else
    begin
      sel_cnt  <= I_SELECT_N ? psram_guard_pkg::CNT_ZERO : sat_inc(sel_cnt);
      high_cnt <= I_SELECT_N ? sat_inc(high_cnt) : psram_guard_pkg::CNT_ZERO;
      addr_cnt <= (I_SELECT_N || addr_chg) ? psram_guard_pkg::CNT_ZERO : sat_inc(addr_cnt);
      addr_q   <= I_ADDR;
    end
  end

  // Write pulse timing; a long write shorter than the cycle time is flagged
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      wr_cnt    <= psram_guard_pkg::CNT_ZERO;
      writing_q <= 1'b0;
      ext_need  <= 1'b0;
      O_LONG_OP <= 1'b0;
    end
    else
    begin
      wr_cnt    <= writing ? sat_inc(wr_cnt) : psram_guard_pkg::CNT_ZERO;
      writing_q <= writing;
      O_LONG_OP <= long_op;
      if (writing && long_op)
        ext_need <= 1'b1;
      else if (!writing)
        ext_need <= 1'b0;
    end
  end

  // ****************************************************************
  // Refresh scheduling
  // ****************************************************************
  // Page mode owns the address pins, so only async address changes count
  assign slot   = (I_SELECT_N && high_cnt >= psram_guard_pkg::CBPH_CYC)
               || (I_MODE == psram_guard_pkg::MODE_ASYNC && !I_SELECT_N && addr_chg)
               || (writing && ext_need && wr_cnt == psram_guard_pkg::WC_CYC)
               || (state == psram_guard_pkg::BURST_ROW);
  assign go_now = pend && slot;

  // A new request in the grant cycle is kept, so set wins over clear
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      pend         <= 1'b0;
      O_REFRESH_GO <= 1'b0;
    end
    else
    begin
      pend         <= I_REFRESH_REQ || (pend && !go_now);
      O_REFRESH_GO <= go_now;
    end
  end

  // ****************************************************************
  // Page reads
  // ****************************************************************
  // Slow flag only falls with select high, so it cannot race a new set
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
      slow <= 1'b0;
    else if (I_SELECT_N)
      slow <= 1'b0;
    else if (I_MODE == psram_guard_pkg::MODE_PAGE && reading && long_sel)
      slow <= 1'b1;
  end

  // Access timer: page hits use the short time unless reads were slowed
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      acc_cnt      <= psram_guard_pkg::CNT_ZERO;
      last_page    <= 18'h0_0000;
      page_valid   <= 1'b0;
      O_DATA_READY <= 1'b0;
      O_SLOW_READ  <= 1'b0;
    end
    else
    begin
      O_SLOW_READ <= slow;
      if (I_SELECT_N)
        page_valid <= 1'b0;
      if (reading && (addr_chg || !page_valid))
      begin
        last_page  <= I_ADDR[21:psram_guard_pkg::PAGE_BITS];
        page_valid <= 1'b1;
        if (I_MODE == psram_guard_pkg::MODE_PAGE && page_valid && !slow
            && I_ADDR[21:psram_guard_pkg::PAGE_BITS] == last_page)
          acc_cnt <= psram_guard_pkg::APA_CYC;
        else
          acc_cnt <= psram_guard_pkg::AA_CYC;
        O_DATA_READY <= 1'b0;
      end
      else if (acc_cnt != psram_guard_pkg::CNT_ZERO)
      begin
        acc_cnt      <= acc_cnt - 7'h01;
        O_DATA_READY <= reading && acc_cnt == 7'h01;
      end
      else
        O_DATA_READY <= reading && page_valid;
    end
  end

  // ****************************************************************
  // Burst row crossing
  // ****************************************************************
  assign advance  = writing || reading;
  assign next_col = burst_addr[6:0] + 7'h01;

  // Next burst state; select high always ends the burst
  always_comb
  begin
    next_state = state;
    unique case (state)
      psram_guard_pkg::BURST_IDLE:
        if (!I_SELECT_N && I_MODE == psram_guard_pkg::MODE_BURST && !I_ADDRESS_LATCH_N)
          next_state = psram_guard_pkg::BURST_RUN;
      psram_guard_pkg::BURST_RUN:
        if (I_SELECT_N)
          next_state = psram_guard_pkg::BURST_IDLE;
        else if (advance && next_col == psram_guard_pkg::CNT_ZERO)
          next_state = psram_guard_pkg::BURST_ROW;
      psram_guard_pkg::BURST_ROW:
        if (I_SELECT_N)
          next_state = psram_guard_pkg::BURST_IDLE;
        else if (wait_cnt == 7'h01)
          next_state = psram_guard_pkg::BURST_RUN;
      default:
        next_state = psram_guard_pkg::BURST_IDLE;
    endcase
  end

  // Burst address, row-open wait and the age of the current row
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      state      <= psram_guard_pkg::BURST_IDLE;
      burst_addr <= 22'h00_0000;
      wait_cnt   <= psram_guard_pkg::CNT_ZERO;
      row_age    <= psram_guard_pkg::CNT_ZERO;
      O_WAIT     <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      O_WAIT <= next_state == psram_guard_pkg::BURST_ROW;
      if (state == psram_guard_pkg::BURST_IDLE)
        burst_addr <= I_ADDR;
      else if (state == psram_guard_pkg::BURST_RUN && advance)
        burst_addr <= burst_addr + 22'h00_0001;
      wait_cnt <= (next_state == psram_guard_pkg::BURST_ROW && state != next_state)
                ? psram_guard_pkg::ROW_CYC
                : ((wait_cnt != psram_guard_pkg::CNT_ZERO) ? wait_cnt - 7'h01 : wait_cnt);
      row_age  <= (next_state == psram_guard_pkg::BURST_RUN && state == psram_guard_pkg::BURST_RUN)
                ? sat_inc(row_age) : psram_guard_pkg::CNT_ZERO;
    end
  end

  // Sticky fault for broken windows, kept until select rises; set wins
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
      O_WINDOW_FAULT <= 1'b0;
    else if ((write_done && ext_need && wr_cnt < psram_guard_pkg::WC_CYC)
             || (state == psram_guard_pkg::BURST_RUN
                 && row_age >= psram_guard_pkg::CEM_CYC))
      O_WINDOW_FAULT <= 1'b1;
    else if (I_SELECT_N)
      O_WINDOW_FAULT <= 1'b0;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  grant_needs_req_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_REFRESH_GO |-> $past(pend)) else $error("refresh granted without request");
  async_read_free_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (I_MODE == psram_guard_pkg::MODE_ASYNC && reading) |=> !O_LONG_OP)
    else $error("async read flagged as long");
  page_addr_nogo_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (I_MODE == psram_guard_pkg::MODE_PAGE && !I_SELECT_N && !writing) |=> !O_REFRESH_GO)
    else $error("page read address used for refresh");
  slow_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (slow && !I_SELECT_N) |=> ##1 O_SLOW_READ || $past(I_SELECT_N))
    else $error("slow read dropped while selected");
  slow_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    I_SELECT_N |=> !slow ##1 !O_SLOW_READ) else $error("slow read kept after select high");
  standby_slot_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    ($past(I_SELECT_N) && I_SELECT_N && pend) |=> O_REFRESH_GO)
    else $error("standby gave no refresh");
  row_wait_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (state == psram_guard_pkg::BURST_RUN && !I_SELECT_N && advance && next_col == 7'h00)
    |=> O_WAIT ##1 (O_WAIT || $past(I_SELECT_N)) ##1 !O_WAIT)
    else $error("row crossing wait wrong");
  burst_end_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (state != psram_guard_pkg::BURST_IDLE && I_SELECT_N)
    |=> state == psram_guard_pkg::BURST_IDLE && !O_WAIT) else $error("burst not ended");
  short_ext_write_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (write_done && ext_need && wr_cnt < psram_guard_pkg::WC_CYC) |=> O_WINDOW_FAULT)
    else $error("short extended write not flagged");
  row_age_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (state == psram_guard_pkg::BURST_RUN && row_age >= psram_guard_pkg::CEM_CYC) |=> O_WINDOW_FAULT)
    else $error("burst row window not flagged");

endmodule

// *** tb/psram_ctrl_model.sv ***
// Model of the memory controller that drives the guard's bus.
// Assumes one bench process calls its tasks; changes land after falling edges.
`timescale 1ns/10ps
module psram_ctrl_model
(
  // Clock
  input  wire logic        i_clk,
  // Memory bus
  output logic             o_select_n,
  output logic [21:0]      o_addr,
  output logic             o_write_n,
  output logic             o_oe_n,
  output logic             o_latch_n
);
  // Select-low age, kept to choose normal or extended writes
  int hold_cnt = 0;
  always @(posedge i_clk)
    hold_cnt <= o_select_n ? 0 : hold_cnt + 1;

  // Deselected address shows the inverse so stale values never match
  task automatic put(input logic s, input logic [21:0] a, input logic w,
                     input logic o, input logic l);
    @(negedge i_clk);
    o_select_n = s;
    o_addr     = s ? ~o_addr : a;
    o_write_n  = w;
    o_oe_n     = o;
    o_latch_n  = l;
  endtask

  // Holds the bus still for n cycles
  task automatic hold(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Write pulse of n cycles; long holds use n above the write cycle time
  task automatic wr(input logic [21:0] a, input int n);
    put(1'b0, a, 1'b0, 1'b1, 1'b1);
    hold(n - 1);
    put(1'b0, a, 1'b1, 1'b1, 1'b1);
  endtask

  // Pulse length picked from the select-low age; select alone is the cautious measure
  task automatic wr_auto(input logic [21:0] a);
    wr(a, (hold_cnt >= int'(psram_guard_pkg::CEM_CYC))
          ? int'(psram_guard_pkg::WC_CYC) + 1 : 1);
  endtask

  // Bus parked deselected at time zero
  initial
  begin
    o_select_n = 1'b1;
    o_addr     = 22'h00_0000;
    o_write_n  = 1'b1;
    o_oe_n     = 1'b1;
    o_latch_n  = 1'b1;
  end
endmodule

// *** tb/test_psram_refresh_window_guard.sv ***
// Self-checking bench for the refresh window guard.
// Assumes the controller model drives the bus and the bench drives mode and refresh.
`timescale 1ns/10ps
module test_psram_refresh_window_guard;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic        req = 1'b0;
  logic        sel_n, we_n, oe_n, adv_n;
  logic [21:0] addr;
  logic        go, long_op, slow, ready, wt, fault;
  int          fail_count = 0;
  int          checks = 0;
  int          n;

  // ****************************************************************
  // Clock and instances
  // ****************************************************************
  initial forever #20 clk = ~clk;
  psram_ctrl_model i_psram_ctrl_model (.i_clk(clk), .o_select_n(sel_n),
    .o_addr(addr), .o_write_n(we_n), .o_oe_n(oe_n), .o_latch_n(adv_n));
  psram_refresh_window_guard i_psram_refresh_window_guard (.I_CLK_SYS(clk),
    .I_RST_N(rst_n), .I_MODE(mode), .I_REFRESH_REQ(req), .I_SELECT_N(sel_n),
    .I_ADDR(addr), .I_WRITE_N(we_n), .I_OUTPUT_EN_N(oe_n),
    .I_ADDRESS_LATCH_N(adv_n), .O_REFRESH_GO(go), .O_LONG_OP(long_op),
    .O_SLOW_READ(slow), .O_DATA_READY(ready), .O_WAIT(wt),
    .O_WINDOW_FAULT(fault));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t %s seen %0h expected %0h", $time, m, seen, exp);
    end
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return go;
      2: return slow;
      3: return ready;
      4: return wt;
      default: return fault;
    endcase
  endfunction

  // Counts edges until output k is high; a hang ends the run
  task automatic wait_for(input int k, input int lim, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge clk);
      cnt++;
    end while (pick(k) !== 1'b1 && cnt < lim);
    chk(pick(k), 1'b1, "awaited output high");
    if (pick(k) !== 1'b1)
      close_out();
  endtask

  // Reset for 21 cycles in the given mode, outputs must all be low
  task automatic start(input logic [1:0] m);
    @(negedge clk);
    rst_n = 1'b0;
    mode  = m;
    i_psram_ctrl_model.put(1'b1, 22'h00_0000, 1'b1, 1'b1, 1'b1);
    i_psram_ctrl_model.hold(20);
    rst_n = 1'b1;
    @(negedge clk);
    chk({go, long_op, slow, ready, wt, fault}, 32'h0000_0000, "reset");
  endtask

  task automatic pulse_req();
    @(negedge clk) req = 1'b1;
    @(negedge clk) req = 1'b0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Standby grant lands two edges after the request, for one cycle
  task automatic s_standby();
    start(psram_guard_pkg::MODE_ASYNC);
    pulse_req();
    chk(go, 1'b0, "early grant");
    @(negedge clk) chk(go, 1'b1, "standby grant");
    @(negedge clk) chk(go, 1'b0, "grant width");
  endtask

  // Async writes: long select and address means extended timing
  task automatic s_async();
    start(psram_guard_pkg::MODE_ASYNC);
    i_psram_ctrl_model.put(1'b0, 22'h00_0040, 1'b1, 1'b1, 1'b1);
    i_psram_ctrl_model.hold(110);
    i_psram_ctrl_model.wr(22'h00_0040, 1);
    i_psram_ctrl_model.hold(2);
    chk(fault, 1'b1, "short extended write");
    i_psram_ctrl_model.put(1'b1, 22'h00_0000, 1'b1, 1'b1, 1'b1);
    i_psram_ctrl_model.hold(3);
    chk(fault, 1'b0, "fault release");
    i_psram_ctrl_model.put(1'b0, 22'h00_0041, 1'b1, 1'b1, 1'b1);
    i_psram_ctrl_model.hold(110);
    i_psram_ctrl_model.put(1'b0, 22'h00_0041, 1'b0, 1'b1, 1'b1);
    i_psram_ctrl_model.hold(2);
    chk(long_op, 1'b1, "long write");
    i_psram_ctrl_model.wr_auto(22'h00_0041);
    i_psram_ctrl_model.hold(2);
    chk(fault, 1'b0, "stretched write");
    // Address moves every 61 cycles: select long but address short
    for (int i = 0; i < 2; i++)
    begin
      i_psram_ctrl_model.put(1'b0, 22'h00_0050 + 22'(i), 1'b1, 1'b1, 1'b1);
      i_psram_ctrl_model.hold(60);
    end
    i_psram_ctrl_model.wr(22'h00_0051, 1);
    i_psram_ctrl_model.hold(2);
    chk({long_op, fault}, 32'h0000_0000, "address short");
    // Long reads are free in async mode; an address change frees refresh
    i_psram_ctrl_model.put(1'b0, 22'h00_0060, 1'b1, 1'b0, 1'b1);
    i_psram_ctrl_model.hold(110);
    chk(long_op, 1'b0, "async long read");
    pulse_req();
    i_psram_ctrl_model.hold(3);
    chk(go, 1'b0, "no slot");
    i_psram_ctrl_model.put(1'b0, 22'h00_0061, 1'b1, 1'b0, 1'b1);
    wait_for(0, 4, n);
  endtask

  // Page reads: hit is fast until select is held long
  task automatic s_page();
    start(psram_guard_pkg::MODE_PAGE);
    i_psram_ctrl_model.put(1'b0, 22'h00_0100, 1'b1, 1'b0, 1'b1);
    wait_for(3, 8, n);
    chk(n, int'(psram_guard_pkg::AA_CYC) + 1, "page miss");
    i_psram_ctrl_model.put(1'b0, 22'h00_0101, 1'b1, 1'b0, 1'b1);
    wait_for(3, 8, n);
    chk(n, int'(psram_guard_pkg::APA_CYC) + 1, "page hit");
    pulse_req();
    i_psram_ctrl_model.put(1'b0, 22'h00_0102, 1'b1, 1'b0, 1'b1);
    i_psram_ctrl_model.hold(3);
    chk(go, 1'b0, "page address no slot");
    i_psram_ctrl_model.hold(100);
    wait_for(2, 8, n);
    i_psram_ctrl_model.put(1'b0, 22'h00_0103, 1'b1, 1'b0, 1'b1);
    wait_for(3, 8, n);
    chk(n, int'(psram_guard_pkg::AA_CYC) + 1, "slow hit");
    i_psram_ctrl_model.put(1'b1, 22'h00_0000, 1'b1, 1'b1, 1'b1);
    wait_for(0, 4, n);
    i_psram_ctrl_model.hold(2);
    chk(slow, 1'b0, "slow cleared");
  endtask

  // Burst: row crossing raises wait and grants refresh; a stall faults
  task automatic s_burst();
    start(psram_guard_pkg::MODE_BURST);
    // Request only once select is low, else standby would take it first
    i_psram_ctrl_model.put(1'b0, 22'h00_007E, 1'b1, 1'b1, 1'b0);
    pulse_req();
    i_psram_ctrl_model.put(1'b0, 22'h00_007E, 1'b1, 1'b0, 1'b1);
    wait_for(4, 6, n);
    wait_for(0, 4, n);
    i_psram_ctrl_model.put(1'b0, 22'h00_007E, 1'b1, 1'b1, 1'b1);
    i_psram_ctrl_model.hold(5);
    chk({wt, fault}, 32'h0000_0000, "row opened");
    i_psram_ctrl_model.hold(105);
    chk(fault, 1'b1, "burst stalled");
    i_psram_ctrl_model.put(1'b1, 22'h00_0000, 1'b1, 1'b1, 1'b1);
    i_psram_ctrl_model.hold(3);
    chk({wt, fault}, 32'h0000_0000, "burst end");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    s_standby();
    s_async();
    s_page();
    s_burst();
    close_out();
  end
endmodule
